// ---- urs_pkg.sv ----
package urs_pkg;
  // Register byte offsets
  localparam logic [7:0] URS_STAT_OFS = 8'h00;
  localparam logic [7:0] URS_DATA_OFS = 8'h04;
  localparam logic [7:0] URS_ISTAT_OFS = 8'h08;
  localparam logic [7:0] URS_IMASK_OFS = 8'h0C;
  localparam logic [7:0] URS_CFG_OFS = 8'h10;
  // Status and control field positions
  localparam int URS_B_AVAIL = 0;
  localparam int URS_B_OVR = 1;
  localparam int URS_B_FRAMING_ERROR_FLAG = 2;
  localparam int URS_B_PARITY_ERROR_FLAG = 3;
  localparam int URS_B_IDLE = 4;
  localparam int URS_B_ADDR_DETECT_EN = 5;
  localparam int URS_B_MODE = 6;
  localparam int URS_B_TXE = 8;
  // Receive buffer entry layout: {framing_error_flag, parity_error_flag, data[8:0]}
  localparam int URS_ENTRY_W = 11;
  localparam int URS_DATA_W = 9;
  localparam int URS_E_PARITY_ERROR_FLAG = 9;
  localparam int URS_E_FRAMING_ERROR_FLAG = 10;
  localparam int URS_RX_DEPTH = 4;
  localparam int URS_RX_3Q_LEVEL = 3;
  // Receive interrupt modes and data formats
  localparam logic [1:0] URS_MODE_FULL = 2'h3;
  localparam logic [1:0] URS_MODE_3Q = 2'h2;
  localparam logic [1:0] URS_FMT_9BIT = 2'h3;
  // Interrupt status bits
  localparam int URS_I_RX = 0;
  localparam int URS_I_OVR = 1;
  localparam int URS_I_PARITY_ERROR_FLAG = 2;
  localparam int URS_I_FRAMING_ERROR_FLAG = 3;
  localparam int URS_IRQ_W = 4;
  // Reset values
  localparam logic [1:0] URS_MODE_RST = 2'h0;
  localparam logic [1:0] URS_FMT_RST = 2'h0;
  localparam logic [3:0] URS_IMASK_RST = 4'h0;
  // Transmit-empty flag lag, in clock cycles
  localparam int URS_TX_EMPTY_DLY = 2;
  // Bus responses
  localparam logic [1:0] URS_RESP_OKAY = 2'h0;
  localparam logic [1:0] URS_RESP_SLVERR = 2'h2;
endpackage : urs_pkg

// ---- urs_rx_buffer.sv ----
`timescale 1ns/1ps
module urs_rx_buffer
  import urs_pkg::*;
#(
  parameter int WIDTH = URS_ENTRY_W,
  parameter int DEPTH = URS_RX_DEPTH
)
(
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Registered read port
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  // Storage, no reset: contents are only read behind a nonzero count
  logic [WIDTH-1:0] mem [DEPTH];

  // Write side
  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read side forwards a same-cycle write so the head is never stale
  always_ff @(posedge clk)
  begin
    if (wr_en && (wr_addr == rd_addr))
    begin
      rd_data <= wr_data;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : urs_rx_buffer

// ---- urs_top.sv ----
`timescale 1ns/1ps
module urs_top
  import urs_pkg::*;
#(
  parameter int RX_DEPTH = URS_RX_DEPTH
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Receive shift register side
  input wire logic rx_char_done,
  input wire logic [URS_DATA_W-1:0] rx_char_data,
  input wire logic rx_char_parity_error_flag,
  input wire logic rx_char_framing_error_flag,
  input wire logic rx_active,
  output logic rx_shift_flush,
  // Transmit side
  input wire logic tx_load,
  input wire logic tx_all_idle,
  // Interrupt
  output logic irq
);
  localparam int PW = $clog2(RX_DEPTH);
  localparam int CW = $clog2(RX_DEPTH + 1);
  localparam int DL = URS_TX_EMPTY_DLY;

  // Bus holding registers
  logic aw_full_reg;
  logic [7:0] aw_addr_reg;
  logic w_full_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // Control registers written by software
  logic [1:0] rx_irq_mode_reg;
  logic addr_detect_en_reg;
  logic [1:0] data_format_select_reg;
  logic [URS_IRQ_W-1:0] irq_mask_reg;

  // Status held by the block
  logic overrun_flag_reg;
  logic rx_idle_flag_reg;
  logic tx_shifter_empty_reg;
  logic [DL-1:0] tx_load_pipe_reg;
  logic [URS_IRQ_W-1:0] irq_stat_reg;

  // Receive buffer bookkeeping
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic [PW-1:0] rd_ptr_next;
  logic [URS_ENTRY_W-1:0] head;

  // Decoded strobes
  logic wr_fire;
  logic stat_wr;
  logic rd_fire;
  logic pop;
  logic addr_ok;
  logic push_req;
  logic push;
  logic buf_full;
  logic overrun_set;
  logic ovr_clear;
  logic rx_event;
  logic data_avail;
  logic [CW-1:0] count_after;
  logic [URS_IRQ_W-1:0] irq_events;
  logic [15:0] stat_word;

  // Head of buffer, read at the next pointer so it updates in the same cycle as its pointer
  urs_rx_buffer #(
    .WIDTH(URS_ENTRY_W),
    .DEPTH(RX_DEPTH)
  ) u_rx_buffer (
    .clk(mclk),
    .wr_en(push),
    .wr_addr(wr_ptr_reg),
    .wr_data({rx_char_framing_error_flag, rx_char_parity_error_flag, rx_char_data}),
    .rd_addr(rd_ptr_next),
    .rd_data(head)
  );

  // Bus strobes and receive decisions
  always_comb
  begin
    wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
    stat_wr = wr_fire && (aw_addr_reg == URS_STAT_OFS) && w_strb_reg[0];
    rd_fire = s_axi_arvalid && s_axi_arready;
    data_avail = (count_reg != '0);
    pop = rd_fire && (s_axi_araddr == URS_DATA_OFS) && data_avail;
    buf_full = (count_reg == CW'(RX_DEPTH));
    // Ninth bit only matters in the nine-bit format
    addr_ok = !(addr_detect_en_reg && (data_format_select_reg == URS_FMT_9BIT))
      || rx_char_data[URS_DATA_W-1];
    // A standing overrun blocks transfers until software clears it
    push_req = rx_char_done && addr_ok && !overrun_flag_reg;
    // A read in the same cycle frees a slot, so it is not an overrun
    overrun_set = push_req && buf_full && !pop;
    push = push_req && !overrun_set;
    // One-to-zero write; an overrun in that cycle would win, but cannot occur
    ovr_clear = stat_wr && overrun_flag_reg && !w_data_reg[URS_B_OVR]
      && !overrun_set;
    count_after = count_reg + CW'(push) - CW'(pop);
    rd_ptr_next = ovr_clear ? '0 : rd_ptr_reg + PW'(pop);
  end

  // Receive interrupt condition by mode
  always_comb
  begin
    rx_event = 1'b0;
    if (push)
    begin
      if (rx_irq_mode_reg == URS_MODE_FULL)
      begin
        rx_event = (count_after == CW'(RX_DEPTH));
      end
      else if (rx_irq_mode_reg == URS_MODE_3Q)
      begin
        rx_event = (count_after == CW'(URS_RX_3Q_LEVEL));
      end
      else
      begin
        rx_event = 1'b1;
      end
    end
    irq_events = '0;
    irq_events[URS_I_RX] = rx_event;
    irq_events[URS_I_OVR] = overrun_set;
    irq_events[URS_I_PARITY_ERROR_FLAG] = push && rx_char_parity_error_flag;
    irq_events[URS_I_FRAMING_ERROR_FLAG] = push && rx_char_framing_error_flag;
  end

  // Status and control word as software sees it
  always_comb
  begin
    stat_word = '0;
    stat_word[URS_B_AVAIL] = data_avail;
    stat_word[URS_B_OVR] = overrun_flag_reg;
    // Error flags describe the head character, zero when empty
    stat_word[URS_B_FRAMING_ERROR_FLAG] = data_avail && head[URS_E_FRAMING_ERROR_FLAG];
    stat_word[URS_B_PARITY_ERROR_FLAG] = data_avail && head[URS_E_PARITY_ERROR_FLAG];
    stat_word[URS_B_IDLE] = rx_idle_flag_reg;
    stat_word[URS_B_ADDR_DETECT_EN] = addr_detect_en_reg;
    stat_word[URS_B_MODE +: 2] = rx_irq_mode_reg;
    stat_word[URS_B_TXE] = tx_shifter_empty_reg;
  end

  // Write channel capture: each channel is taken once per write
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_full_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      // Response taken, reopen both channels
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= URS_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      if ((aw_addr_reg == URS_STAT_OFS) || (aw_addr_reg == URS_ISTAT_OFS)
        || (aw_addr_reg == URS_IMASK_OFS) || (aw_addr_reg == URS_CFG_OFS))
      begin
        s_axi_bresp <= URS_RESP_OKAY;
      end
      else
      begin
        s_axi_bresp <= URS_RESP_SLVERR;
      end
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control registers; only byte lane 0 carries fields
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_irq_mode_reg <= URS_MODE_RST;
      addr_detect_en_reg <= 1'b0;
      data_format_select_reg <= URS_FMT_RST;
      irq_mask_reg <= URS_IMASK_RST;
    end
    else if (wr_fire && w_strb_reg[0])
    begin
      if (aw_addr_reg == URS_STAT_OFS)
      begin
        rx_irq_mode_reg <= w_data_reg[URS_B_MODE +: 2];
        addr_detect_en_reg <= w_data_reg[URS_B_ADDR_DETECT_EN];
      end
      if (aw_addr_reg == URS_CFG_OFS)
      begin
        data_format_select_reg <= w_data_reg[1:0];
      end
      if (aw_addr_reg == URS_IMASK_OFS)
      begin
        irq_mask_reg <= w_data_reg[URS_IRQ_W-1:0];
      end
    end
  end

  // Overrun flag: set by hardware, cleared by writing zero
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      overrun_flag_reg <= 1'b0;
      rx_shift_flush <= 1'b0;
    end
    else
    begin
      if (overrun_set)
      begin
        overrun_flag_reg <= 1'b1;
      end
      else if (ovr_clear)
      begin
        overrun_flag_reg <= 1'b0;
      end
      // Pulse to empty the shift register on the clearing write
      rx_shift_flush <= ovr_clear;
    end
  end

  // Receive buffer pointers and fill level
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else if (ovr_clear)
    begin
      // Flush drops every stored character
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg + PW'(push);
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_after;
    end
  end

  // Receiver idle flag follows the shift register activity
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_idle_flag_reg <= 1'b1;
    end
    else
    begin
      rx_idle_flag_reg <= !rx_active;
    end
  end

  // Transmit-empty flag holds its old value while a load ages
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_load_pipe_reg <= '0;
      tx_shifter_empty_reg <= 1'b1;
    end
    else
    begin
      tx_load_pipe_reg <= {tx_load_pipe_reg[DL-2:0], tx_load};
      if (tx_load_pipe_reg[DL-1])
      begin
        tx_shifter_empty_reg <= 1'b0;
      end
      else if (!(tx_load || (|tx_load_pipe_reg[DL-2:0])))
      begin
        tx_shifter_empty_reg <= tx_all_idle;
      end
    end
  end

  // Sticky interrupt status; a new event beats a same-cycle clear
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_stat_reg <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_fire && w_strb_reg[0] && (aw_addr_reg == URS_ISTAT_OFS))
      begin
        irq_stat_reg <= (irq_stat_reg & ~w_data_reg[URS_IRQ_W-1:0]) | irq_events;
      end
      else
      begin
        irq_stat_reg <= irq_stat_reg | irq_events;
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read channel; a read of the data word pops the head
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= URS_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= URS_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      unique case (s_axi_araddr)
        URS_STAT_OFS: s_axi_rdata[15:0] <= stat_word;
        URS_DATA_OFS: s_axi_rdata[URS_DATA_W-1:0] <= data_avail ? head[URS_DATA_W-1:0] : '0;
        URS_ISTAT_OFS: s_axi_rdata[URS_IRQ_W-1:0] <= irq_stat_reg;
        URS_IMASK_OFS: s_axi_rdata[URS_IRQ_W-1:0] <= irq_mask_reg;
        URS_CFG_OFS: s_axi_rdata[1:0] <= data_format_select_reg;
        default: s_axi_rresp <= URS_RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  rx_full_irq_a: assert property ((push && (rx_irq_mode_reg == URS_MODE_FULL)
    && (count_reg == CW'(RX_DEPTH - 1)) && !pop) |=> irq_stat_reg[URS_I_RX])
    else $error("full-mode receive interrupt missing");
  rx_3q_irq_a: assert property ((push && (rx_irq_mode_reg == URS_MODE_3Q)
    && (count_reg == CW'(URS_RX_3Q_LEVEL - 1)) && !pop) |=> irq_stat_reg[URS_I_RX])
    else $error("three-quarter interrupt missing");
  rx_any_irq_a: assert property (push && !rx_irq_mode_reg[1]
    |=> irq_stat_reg[URS_I_RX])
    else $error("per-character receive interrupt missing");
  addr_filter_a: assert property (rx_char_done && addr_detect_en_reg
    && (data_format_select_reg == URS_FMT_9BIT) && !rx_char_data[URS_DATA_W-1] |-> !push)
    else $error("data character accepted in address mode");
  rx_idle_a: assert property ($rose(rx_active) |=> !rx_idle_flag_reg)
    else $error("idle flag stays high while receiving");
  ovr_set_a: assert property (push_req && buf_full && !pop
    |=> overrun_flag_reg && $stable(count_reg))
    else $error("overrun not flagged on full buffer");
  ovr_flush_a: assert property (ovr_clear
    |=> (count_reg == '0) && rx_shift_flush && !overrun_flag_reg)
    else $error("overrun clear did not flush");
  avail_read_a: assert property (rd_fire && (s_axi_araddr == URS_STAT_OFS)
    |=> s_axi_rdata[URS_B_AVAIL] == ($past(count_reg) != '0))
    else $error("data-available flag wrong");
  head_err_a: assert property (rd_fire && (s_axi_araddr == URS_STAT_OFS) && data_avail
    |=> s_axi_rdata[URS_B_PARITY_ERROR_FLAG] == $past(head[URS_E_PARITY_ERROR_FLAG]))
    else $error("parity flag not from head");
  tx_lag_a: assert property (tx_load && tx_shifter_empty_reg && !(|tx_load_pipe_reg)
    |=> tx_shifter_empty_reg ##1 tx_shifter_empty_reg ##1 !tx_shifter_empty_reg)
    else $error("transmit-empty lag wrong");
  no_xfer_a: assert property (overrun_flag_reg && !ovr_clear |=> $stable(wr_ptr_reg))
    else $error("transfer during overrun");

  full_irq_c: cover property (rx_event && (rx_irq_mode_reg == URS_MODE_FULL));
  overrun_c: cover property (overrun_set);
  flush_c: cover property (ovr_clear);
endmodule : urs_top

// ---- urs_line_model.sv ----
`timescale 1ns/1ps
module urs_line_model
  import urs_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Frame requests from the bench
  input wire logic send,
  input wire logic [URS_DATA_W-1:0] char_in,
  input wire logic [1:0] err_in,
  input wire logic [7:0] frame_len,
  output logic busy,
  // Shift register side of the block
  input wire logic flush,
  output logic char_done,
  output logic [URS_DATA_W-1:0] char_data,
  output logic char_parity_error_flag,
  output logic char_framing_error_flag,
  output logic line_active
);
  logic [7:0] left_reg; // Cycles left in the frame
  logic [URS_DATA_W-1:0] shift_reg; // Character on the wire
  logic [1:0] err_reg; // Its errors, {framing, parity}

  assign busy = (left_reg != 8'h00);
  // Receiver looks active for the whole frame
  assign line_active = busy;

  // Frame timing; data lines toggle outside the done cycle so stale values never look valid
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      left_reg <= 8'h00;
      shift_reg <= '0;
      err_reg <= 2'h0;
      char_done <= 1'b0;
      char_data <= '0;
      char_parity_error_flag <= 1'b0;
      char_framing_error_flag <= 1'b0;
    end
    else
    begin
      char_done <= 1'b0;
      char_data <= ~char_data;
      char_parity_error_flag <= ~char_parity_error_flag;
      char_framing_error_flag <= ~char_framing_error_flag;
      if (flush)
      begin
        // Partial character is lost
        left_reg <= 8'h00;
      end
      else if (send && !busy)
      begin
        left_reg <= frame_len;
        shift_reg <= char_in;
        err_reg <= err_in;
      end
      else if (left_reg == 8'h01)
      begin
        // Stop bit reached: hand the character over
        left_reg <= 8'h00;
        char_done <= 1'b1;
        char_data <= shift_reg;
        char_parity_error_flag <= err_reg[0];
        char_framing_error_flag <= err_reg[1];
      end
      else if (busy)
      begin
        left_reg <= left_reg - 8'h01;
      end
    end
  end
endmodule : urs_line_model

// ---- test_uart_receive_status_irq.sv ----
`timescale 1ns/1ps
module test_uart_receive_status_irq
  import urs_pkg::*;
;
  logic mclk = 1'b0; // 40 MHz
  logic reset_n = 1'b0; // Async, active low
  // Bus master side
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  // Line model and transmitter stand-in
  logic send = 1'b0, busy, done, parity_error_flag, framing_error_flag, active, flush;
  logic [8:0] char_in = 9'h000, cdata;
  logic [1:0] err_in = 2'h0;
  logic [7:0] frame_len = 8'h04;
  logic tx_load = 1'b0, tx_all_idle = 1'b1, irq;
  // Bench state
  int n_mismatch = 0, compares = 0, n_flush = 0, m, k, b;
  logic [31:0] lfsr_q = 32'h43BA, d;
  logic [10:0] c, h;
  logic [1:0] r;
  logic [10:0] q[$]; // Characters expected in the buffer

  urs_top dut (.mclk(mclk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_char_done(done),
    .rx_char_data(cdata), .rx_char_parity_error_flag(parity_error_flag), .rx_char_framing_error_flag(framing_error_flag), .rx_active(active),
    .rx_shift_flush(flush), .tx_load(tx_load), .tx_all_idle(tx_all_idle), .irq(irq));

  urs_line_model line (.mclk(mclk), .reset_n(reset_n), .send(send), .char_in(char_in), .err_in(err_in),
    .frame_len(frame_len), .busy(busy), .flush(flush), .char_done(done), .char_data(cdata),
    .char_parity_error_flag(parity_error_flag), .char_framing_error_flag(framing_error_flag), .line_active(active));

  // Clock generator
  initial
  begin
    forever #12.5 mclk = ~mclk;
  end

  // Count flush pulses
  always @(posedge mclk)
  begin
    if (flush === 1'b1)
      n_flush++;
  end

  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {1'b0, s[31:1]} ^ (s[0] ? 32'hA3000000 : 32'h00000000);
  endfunction : lfsr_step

  // Receive interrupt expected after a transfer leaving cnt characters
  function automatic logic rx_irq_exp(input logic [1:0] mode, input int cnt);
    if (!mode[1])
      return 1'b1;
    if (mode == URS_MODE_3Q)
      return cnt == URS_RX_3Q_LEVEL;
    return cnt == URS_RX_DEPTH;
  endfunction : rx_irq_exp

  // Status word with a character at the head, receiver idle, transmitter empty
  function automatic logic [31:0] stat_word(input logic [10:0] hd, input logic [1:0] mode);
    // Bit 3 carries the head's parity error, bit 2 its framing error
    return {23'h0, 1'b1, mode, 1'b0, 1'b1, hd[9], hd[10], 1'b0, 1'b1};
  endfunction : stat_word

  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task report_and_stop;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Write; both channels offered together, each released when taken
  task axi_write(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] resp);
    @(posedge mclk);
    awaddr <= a;
    wdata <= wd;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write

  task axi_read(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] resp);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk);
      if (arready)
        arvalid <= 1'b0;
    end
    while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read

  task rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    axi_read(a, d, r);
    check(d & msk, exp);
  endtask : rd_chk

  // One frame on the line; optionally wait until it has landed
  task send_char(input logic [10:0] ch, input logic [7:0] len, input logic wait_end);
    @(posedge mclk);
    send <= 1'b1;
    char_in <= ch[8:0];
    err_in <= ch[10:9];
    frame_len <= len;
    @(posedge mclk);
    send <= 1'b0;
    @(posedge mclk);
    while (wait_end && busy)
      @(posedge mclk);
    repeat (3) @(posedge mclk);
  endtask : send_char

  // Watchdog
  initial
  begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    rd_chk(URS_STAT_OFS, 32'h00000110, 32'hFFFFFFFF);
    axi_read(8'h14, d, r);
    check({d[31:2], r}, {30'h0, URS_RESP_SLVERR}); // unmapped read
    axi_write(8'h14, 32'hFFFFFFFF, r);
    check(r, URS_RESP_SLVERR); // unmapped write
    // Every interrupt mode, masked in modes 0 and 2, unmasked in modes 1 and 3, four characters then drain
    for (m = 0; m < 4; m++)
    begin
      axi_write(URS_IMASK_OFS, {28'h0, {4{m[0]}}}, r);
      axi_write(URS_STAT_OFS, {24'h0, m[1:0], 6'h00}, r);
      for (k = 1; k <= 4; k++)
      begin
        lfsr_q = lfsr_step(lfsr_q);
        c = lfsr_q[10:0];
        send_char(c, 8'h03 + {5'h0, lfsr_q[13:11]}, 1'b1);
        q.push_back(c);
        axi_read(URS_ISTAT_OFS, d, r);
        check(d, {28'h0, c[10], c[9], 1'b0, rx_irq_exp(m[1:0], k)});
        check(irq, m[0] && (c[10] || c[9] || rx_irq_exp(m[1:0], k)));
        axi_write(URS_ISTAT_OFS, 32'h0000000F, r);
        repeat (2) @(posedge mclk);
        check(irq, 1'b0);
      end
      while (q.size() > 0)
      begin
        h = q.pop_front();
        rd_chk(URS_STAT_OFS, stat_word(h, m[1:0]), 32'h000001FF);
        rd_chk(URS_DATA_OFS, {23'h0, h[8:0]}, 32'hFFFFFFFF);
      end
      rd_chk(URS_STAT_OFS, 32'h0, 32'h1);
    end
    // Overrun: a fifth character meets a full buffer
    axi_write(URS_STAT_OFS, 32'h0, r);
    for (k = 0; k < 5; k++)
    begin
      lfsr_q = lfsr_step(lfsr_q);
      send_char({2'h0, lfsr_q[8:0]}, 8'h04, 1'b1);
      q.push_back({2'h0, lfsr_q[8:0]});
    end
    rd_chk(URS_STAT_OFS, 32'h3, 32'h3);
    rd_chk(URS_ISTAT_OFS, 32'h3, 32'h3);
    h = q.pop_front();
    rd_chk(URS_DATA_OFS, {23'h0, h[8:0]}, 32'hFFFFFFFF);
    axi_write(URS_ISTAT_OFS, 32'h0000000F, r);
    send_char(11'h155, 8'h04, 1'b1);
    rd_chk(URS_ISTAT_OFS, 32'h0, 32'h1);
    // Clear overrun while a long frame is in flight
    send_char(11'h0AA, 8'h3C, 1'b0);
    rd_chk(URS_STAT_OFS, 32'h0, 32'h10);
    axi_write(URS_STAT_OFS, 32'h0, r);
    repeat (80) @(posedge mclk);
    rd_chk(URS_STAT_OFS, 32'h10, 32'h13);
    check(n_flush, 1);
    rd_chk(URS_DATA_OFS, 32'h0, 32'hFFFFFFFF);
    q.delete();
    // Address detect against every data format
    for (m = 0; m < 4; m++)
    begin
      axi_write(URS_CFG_OFS, m, r);
      axi_write(URS_STAT_OFS, 32'h20, r);
      for (b = 0; b < 2; b++)
      begin
        lfsr_q = lfsr_step(lfsr_q);
        c = {2'h0, b[0], lfsr_q[7:0]};
        send_char(c, 8'h05, 1'b1);
        rd_chk(URS_DATA_OFS, (b == 1 || m != 3) ? {23'h0, c[8:0]} : 32'h0, 32'hFFFFFFFF);
      end
    end
    // Transmit-empty flag holds for two cycles after a load
    @(posedge mclk);
    tx_load <= 1'b1;
    tx_all_idle <= 1'b0;
    // Load is a one-cycle pulse from the software side
    @(posedge mclk);
    tx_load <= 1'b0;
    rd_chk(URS_STAT_OFS, 32'h100, 32'h100);
    rd_chk(URS_STAT_OFS, 32'h0, 32'h100);
    tx_all_idle <= 1'b1;
    repeat (3) @(posedge mclk);
    rd_chk(URS_STAT_OFS, 32'h100, 32'h100);
    report_and_stop();
  end
endmodule : test_uart_receive_status_irq
